// >>> design/sbig_gen.sv
// Break and idle frame generator of the serial transmitter.
`timescale 1ns/10ps

module sbig_gen #(
	parameter int DIV = sbig_pkg::SBIG_DIV_DEF
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire sbig_pkg::sbig_ctrl_s serial_control_two,
	output sbig_pkg::sbig_stat_s  status
);
	import sbig_pkg::*;

	sbig_state_e state;
	sbig_state_e next_state;
	logic [3:0]  bit_count;
	logic [3:0]  frame_len;
	logic        tick;
	logic        start;
	logic        frame_end;
	logic        tx_on_d;
	logic        break_seen;
	logic        idle_pend;
	logic        txd;
	logic        tx_on_rise;
	logic        break_request_d;
	logic        break_rise;
	logic        want_break;
	logic        busy;
	logic        sending_break;
	logic        sending_idle;

	// ----------------------------------------------------------------
	// Bit clock
	// ----------------------------------------------------------------
	sbig_bit_tick #(
		.DIV     (DIV)
	) u_tick (
		.clk     (clk),
		.rst_b   (rst_b),
		.restart (start),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// Frame length
	// ----------------------------------------------------------------
	// Frame length is latched at frame start so a word length change mid
	// frame cannot stretch or cut the break.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_len <= SBIG_FRAME_SHORT;
		end else if (start) begin
			frame_len <= serial_control_two.word_long ? SBIG_FRAME_LONG
				: SBIG_FRAME_SHORT;
		end
	end

	assign frame_end = (state != SBIG_ST_WAIT) && tick
		&& (bit_count == frame_len - 4'h1);

	// ----------------------------------------------------------------
	// Request capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_on_d <= 1'b0;
		end else begin
			tx_on_d <= serial_control_two.tx_on;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			break_request_d <= 1'b0;
		end else begin
			break_request_d <= serial_control_two.break_request;
		end
	end

	assign tx_on_rise = serial_control_two.tx_on && !tx_on_d;
	assign break_rise = serial_control_two.break_request && !break_request_d;

	// A rising tx_on queues an idle; the set wins over the consuming clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_pend <= 1'b0;
		end else if (tx_on_rise) begin
			idle_pend <= 1'b1;
		end else if (start && next_state == SBIG_ST_IDLE) begin
			idle_pend <= 1'b0;
		end
	end

	// Only a rise of break_request is remembered, so a one-cycle pulse still
	// sends one break. A rise in the cycle that starts a break is served by
	// that break, which is why the clear is tested first; the cost is that a
	// second pulse landing in exactly that cycle is not counted.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			break_seen <= 1'b0;
		end else if (start && next_state == SBIG_ST_BREAK) begin
			break_seen <= 1'b0;
		end else if (break_rise) begin
			break_seen <= 1'b1;
		end
	end

	// A held request is served from its level at each frame end, so once it
	// falls nothing stays latched and no break follows the one on the wire.
	assign want_break = break_seen
		|| (frame_end && serial_control_two.break_request);

	// ----------------------------------------------------------------
	// Frame sequencing
	// ----------------------------------------------------------------
	// Frames start only from WAIT or at a frame end, so a break is never
	// chained into a second break by a stale request.
	always_comb begin
		next_state = state;
		start      = 1'b0;
		if (serial_control_two.tx_on && (state == SBIG_ST_WAIT || frame_end)) begin
			if (idle_pend) begin
				next_state = SBIG_ST_IDLE;
				start      = 1'b1;
			end else if (want_break) begin
				next_state = SBIG_ST_BREAK;
				start      = 1'b1;
			end else begin
				next_state = SBIG_ST_WAIT;
			end
		end else if (frame_end || !serial_control_two.tx_on) begin
			next_state = SBIG_ST_WAIT;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SBIG_ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Bit counter
	// ----------------------------------------------------------------
	// The count is cleared on every frame start, so a frame cut short by a
	// falling tx_on leaves nothing stale behind for the next one.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_count <= SBIG_BIT_RESET;
		end else if (start || frame_end) begin
			bit_count <= SBIG_BIT_RESET;
		end else if (tick) begin
			bit_count <= bit_count + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Line output
	// ----------------------------------------------------------------
	// The line is a flop of its own, fed only by the next-state decode, so no
	// glitch of the frame logic can reach the pin.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txd <= SBIG_LINE_IDLE;
		end else begin
			unique case (next_state)
				SBIG_ST_WAIT:  txd <= SBIG_LINE_IDLE;
				SBIG_ST_IDLE:  txd <= SBIG_LINE_IDLE;
				SBIG_ST_BREAK: txd <= 1'b0;
			endcase
		end
	end

	// The frame flags load from next_state on the same edge as the line, so a
	// watcher never sees them disagree with the pin.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else begin
			busy <= next_state != SBIG_ST_WAIT;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sending_break <= 1'b0;
		end else begin
			sending_break <= next_state == SBIG_ST_BREAK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sending_idle <= 1'b0;
		end else begin
			sending_idle <= next_state == SBIG_ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Status port
	// ----------------------------------------------------------------
	assign status = '{
		txd:           txd,
		busy:          busy,
		sending_break: sending_break,
		sending_idle:  sending_idle
	};

endmodule

// >>> design/sbig_pkg.sv
// Package of constants and carrier types for the break and idle generator.
package sbig_pkg;

	// ----------------------------------------------------------------
	// Frame lengths in bit times
	// ----------------------------------------------------------------
	localparam logic [3:0] SBIG_FRAME_SHORT = 4'ha;
	localparam logic [3:0] SBIG_FRAME_LONG  = 4'hb;

	// ----------------------------------------------------------------
	// Bit clock divider and reset values
	// ----------------------------------------------------------------
	localparam int         SBIG_CLK_HZ      = 50000000;
	localparam int         SBIG_BAUD_DEF    = 19200;
	localparam int         SBIG_DIV_DEF     = SBIG_CLK_HZ / SBIG_BAUD_DEF;
	localparam logic [15:0] SBIG_DIV_RESET  = 16'h0000;
	localparam logic [3:0] SBIG_BIT_RESET   = 4'h0;
	localparam logic       SBIG_LINE_IDLE   = 1'b1;

	// Software control bits of the second serial control register.
	typedef struct packed {
		logic word_long;
		logic tx_on;
		logic break_request;
	} sbig_ctrl_s;

	// Line level and frame flags reported on the status port; the remote receiver sees only txd.
	typedef struct packed {
		logic txd;
		logic busy;
		logic sending_break;
		logic sending_idle;
	} sbig_stat_s;

	typedef enum logic [2:0] {
		SBIG_ST_WAIT  = 3'b001,
		SBIG_ST_IDLE  = 3'b010,
		SBIG_ST_BREAK = 3'b100
	} sbig_state_e;

endpackage

// >>> design/sbig_bit_tick.sv
// Bit-time enable divider for the break and idle generator.
`timescale 1ns/10ps
module sbig_bit_tick #(
	parameter int DIV = sbig_pkg::SBIG_DIV_DEF
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic restart,
	output logic      tick
);
	import sbig_pkg::*;

	localparam logic [15:0] LAST = 16'(DIV - 1);

	logic [15:0] count;

	// A restart aligns the first bit time with the start of a frame.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= SBIG_DIV_RESET;
		end else if (restart || count == LAST) begin
			count <= SBIG_DIV_RESET;
		end else begin
			count <= count + 16'h0001;
		end
	end

	// The tick does not look at restart: a start at a frame end meets a tick where the count wraps anyway, and a tick
	// that meets a start from WAIT is harmless, as frame_end needs a frame state and the bit count clears on start.
	assign tick = (count == LAST);

endmodule

// >>> dv/sbig_gen_sva.sv
// Checker of line timing for the break and idle generator.
`timescale 1ns/10ps
module sbig_gen_sva #(
	parameter int DIV = sbig_pkg::SBIG_DIV_DEF
) (
	input wire logic               clk,
	input wire logic               rst_b,
	input wire sbig_pkg::sbig_ctrl_s serial_control_two,
	input wire sbig_pkg::sbig_stat_s status
);
	import sbig_pkg::*;
	int lo;
	int id;
	int fl;
	int rs;
	logic rq_d;
	assign fl = int'(serial_control_two.word_long ? SBIG_FRAME_LONG : SBIG_FRAME_SHORT) * DIV;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo <= 0;
			id <= 0;
		end else begin
			lo <= status.txd ? 0 : lo + 1;
			id <= status.sending_idle ? id + 1 : 0;
		end
	end
	// Cycles since the last rise of break_request, held once it is far past.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rq_d <= 1'b0;
			rs   <= 0;
		end else begin
			rq_d <= serial_control_two.break_request;
			if (serial_control_two.break_request && !rq_d)
				rs <= 0;
			else if (rs < 100000)
				rs <= rs + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_brk_low; status.sending_break |-> !status.txd; endproperty
	a_brk_low: assert property (p_brk_low) else $error("line high in break");
	property p_quiet; !status.busy |-> status.txd; endproperty
	a_quiet: assert property (p_quiet) else $error("line low while quiet");
	// Back-to-back breaks merge on the wire, so a low run is a whole number of frames.
	property p_short; $rose(status.txd) && !serial_control_two.word_long |-> lo % fl == 0;
	endproperty
	a_short: assert property (p_short) else $error("short break length");
	property p_long; $rose(status.txd) && serial_control_two.word_long |-> lo % fl == 0;
	endproperty
	a_long: assert property (p_long) else $error("long break length");
	// At the frame-end edge of a break a held request keeps the line low.
	property p_rpt; !status.txd && serial_control_two.break_request &&
		serial_control_two.tx_on && lo % fl == fl - 1 |=> !status.txd; endproperty
	a_rpt: assert property (p_rpt) else $error("held break not repeated");
	property p_idle_q; $rose(serial_control_two.tx_on) |-> ##[1:3] status.sending_idle;
	endproperty
	a_idle_q: assert property (p_idle_q) else $error("idle not queued");
	property p_idle_len; $fell(status.sending_idle) |-> id == fl; endproperty
	a_idle_len: assert property (p_idle_len) else $error("idle length");
	property p_idle_hi; status.sending_idle |-> status.txd; endproperty
	a_idle_hi: assert property (p_idle_hi) else $error("line low in idle");
	// No rise since this break began and the request low: this break is the last.
	property p_stop; !status.txd && !serial_control_two.break_request && rs >= fl &&
		lo % fl == fl - 1 |=> status.txd; endproperty
	a_stop: assert property (p_stop) else $error("extra break after request fell");
endmodule
bind sbig_gen sbig_gen_sva #(.DIV(DIV)) u_sva (.clk(clk), .rst_b(rst_b),
	.serial_control_two(serial_control_two), .status(status));

// >>> dv/sbig_rx.sv
// Remote receiver model that totals the time the line is held low.
`timescale 1ns/10ps
module sbig_rx (
	input wire logic clk,
	input wire logic clr,
	input wire logic txd,
	output int       low_cycles
);
	always_ff @(posedge clk) begin
		if (clr)
			low_cycles <= 0;
		else if (!txd)
			low_cycles <= low_cycles + 1;
	end
endmodule

// >>> dv/sbig_gen_tb.sv
// Self-checking testbench of the break and idle generator.
`timescale 1ns/10ps
module sbig_gen_tb;
	import sbig_pkg::*;
	localparam int DIV = 4;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       clr = 1'b0;
	sbig_ctrl_s ctl = '0;
	sbig_stat_s st;
	int         low_cycles;
	int         num_errors = 0;
	int         total_checks = 0;
	always #10 clk = ~clk;
	sbig_gen #(.DIV(DIV)) dut (.clk(clk), .rst_b(rst_b), .serial_control_two(ctl), .status(st));
	sbig_rx rx (.clk(clk), .clr(clr), .txd(st.txd), .low_cycles(low_cycles));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Quiet for several cycles means nothing is still pending behind the frame.
	task automatic settle;
		int n;
		n = 0;
		repeat (600) begin
			@(posedge clk);
			n = (st.busy === 1'b0) ? n + 1 : 0;
			if (n == 6)
				return;
		end
		num_errors++;
	endtask
	task automatic t_single(input logic wl);
		ctl <= '{word_long: wl, tx_on: 1'b0, break_request: 1'b0};
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		ctl.tx_on <= 1'b1;
		@(posedge clk);
		ctl.break_request <= 1'b1;
		@(posedge clk);
		ctl.break_request <= 1'b0;
		settle();
		check(low_cycles, int'(wl ? SBIG_FRAME_LONG : SBIG_FRAME_SHORT) * DIV);
	endtask
	task automatic t_held;
		ctl.word_long <= 1'b0;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		ctl.break_request <= 1'b1;
		repeat (5 * SBIG_FRAME_SHORT * DIV / 2) @(posedge clk);
		ctl.break_request <= 1'b0;
		settle();
		// The request spans three frame starts and falls inside the third break.
		check(low_cycles, 3 * SBIG_FRAME_SHORT * DIV);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(st, {SBIG_LINE_IDLE, 3'h0});
		t_single(1'b0);
		t_single(1'b1);
		t_held();
		t_single(1'b0);
		wrap_up();
	end
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
endmodule
